// file: design/pgct_defines.svh
// offsets, field positions and reset values of the pwm gate current bank
// assumes: included by the package, the register bank and the testbench
`ifndef PGCT_DEFINES_SVH
`define PGCT_DEFINES_SVH

// register offsets on the 5-bit register port
`define PGCT_ADDR_W 5
`define PGCT_OFS_DISCH 5'h0C
`define PGCT_OFS_DRIVE 5'h0D
`define PGCT_OFS_BANK 5'h1D

// bank-select bit position in the bank register
`define PGCT_BANK_BIT 0

// register width and sense capacitor option bit
`define PGCT_DATA_W 16
`define PGCT_BODY_W 15
`define PGCT_SENSE_BIT 15

// per-channel 5-bit current codes
`define PGCT_CH3_CODE_LSB 10
`define PGCT_CH2_CODE_LSB 5
`define PGCT_CH1_CODE_LSB 0

// timing and peak code fields of both drive registers
`define PGCT_BLANK4_LSB 12
`define PGCT_CROSS4_LSB 9
`define PGCT_BLANK3_LSB 6
`define PGCT_PEAK3_LSB 4
`define PGCT_PEAK2_LSB 2
`define PGCT_PEAK1_LSB 0

// reset values of the 15-bit bodies, the option bit and the bank bit
`define PGCT_RST_DISCH 15'h1CE7
`define PGCT_RST_PREDIS 15'h318C
`define PGCT_RST_DRIVE 15'h4900
`define PGCT_RST_SENSE 1'h0
`define PGCT_RST_BANK 1'h0

`endif

// file: design/pgct_pkg.sv
// types shared by the pwm gate current register bank
// assumes: the defines header is on the include path
`include "pgct_defines.svh"

package pgct_pkg;

    typedef logic [4:0] pgct_code_t;
    typedef logic [2:0] pgct_time_t;
    typedef logic [1:0] pgct_peak_t;
    typedef logic [`PGCT_BODY_W-1:0] pgct_body_t;

    // state of the bank top: bank select and registered read data
    typedef struct packed {
        logic bank;
        logic [`PGCT_DATA_W-1:0] rdata;
    } pgct_top_st_t;

    // state of one channel's drive limit selector
    typedef struct packed {
        pgct_peak_t limit;
        logic en;
    } pgct_drv_st_t;

endpackage

// file: design/pgct_field.sv
// one writable register body with a fixed reset value
// assumes: write enable already decoded by the bank, single clock
`timescale 1ns/1ns

module pgct_field
    import pgct_pkg::*;
#(
    parameter int W = 15,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk, // core clock
    input wire logic reset, // sync reset, high
    input wire logic we, // write this body
    input wire logic [W-1:0] wd, // new contents
    output logic [W-1:0] q // stored contents
);
    typedef struct packed {
        logic [W-1:0] val;
    } pgct_field_st_t;

    pgct_field_st_t st_q, st_d;

    // refuse body widths below 1 or above 32 bits
    if (W < 1 || W > 32) begin : g_bad_w
        $error("pgct_field width out of range");
    end

    // next value: hold unless written
    always_comb begin
        st_d = st_q;
        if (we) begin
            st_d.val = wd;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q.val <= RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.val;
endmodule

// file: design/pgct_drive_sel.sv
// drive limit selector for one pwm channel
// assumes: phase flags come synchronous from the gate sequencer
`timescale 1ns/1ns

module pgct_drive_sel
    import pgct_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic reset, // sync reset, high
    input wire pgct_peak_t act_peak, // peak code, active mosfet
    input wire pgct_peak_t fw_peak, // peak code, freewheel mosfet
    input wire logic fw_sel, // freewheel mosfet is switching
    input wire logic pre_phase, // pre-charge or pre-discharge
    input wire logic post_phase, // post-charge phase
    output pgct_peak_t limit, // applied peak code
    output logic limit_en // peak limit in force
);
    pgct_drv_st_t st_q, st_d;

    // peak code applies in pre and post phases, else limit idles at 00
    always_comb begin
        st_d = '0;
        if (pre_phase || post_phase) begin
            st_d.en = 1'b1;
            st_d.limit = fw_sel ? fw_peak : act_peak;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign limit = st_q.limit;
    assign limit_en = st_q.en;
endmodule

// file: design/pgct_bank.sv
// bank-switched pwm gate current and timing registers
// assumes: single clock, register port strobes are one cycle and never
// overlap, and the gate sequencer drives the phase flags synchronously
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "pgct_defines.svh"

////////////////////////////////////////////////////////////////////////
// Behaviour
// - 0x0C: bank 0 discharge, bank 1 predischarge
// - 0x0D: bank 0 active, bank 1 freewheel
// - bit 15 at 0x0C: sense capacitor option
// - three discharge codes, reset 00111
// - three predischarge codes, reset 01100
// - active blank times 14:12, 8:6, reset 100
// - active cross time 11:9, reset 100
// - freewheel register mirrors active layout
// - 2-bit peak drive codes per channel
// - peak code also applies in post-charge
// - bit 15 of 0x0D reads zero
// - freewheel blank4 at 14:12, rw, 100
module pgct_bank
    import pgct_pkg::*;
(
    input wire logic clk, // core clock, 250 MHz
    input wire logic reset, // sync reset, high
    input wire logic [`PGCT_ADDR_W-1:0] addr, // register offset
    input wire logic [`PGCT_DATA_W-1:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [`PGCT_DATA_W-1:0] rdata, // read data, cycle after rd
    output logic bank_sel, // current bank select
    output logic sense_cap_400p, // sense output load up to 400 pF
    output pgct_code_t ch1_active_discharge_code, // ch1 discharge
    output pgct_code_t ch2_active_discharge_code, // ch2 discharge
    output pgct_code_t ch3_active_discharge_code, // ch3 discharge
    output pgct_code_t ch1_initial_predischarge_code, // ch1 init
    output pgct_code_t ch2_initial_predischarge_code, // ch2 init
    output pgct_code_t ch3_initial_predischarge_code, // ch3 init
    output pgct_time_t set4_active_blank_time, // active blank 4
    output pgct_time_t set3_active_blank_time, // active blank 3
    output pgct_time_t set4_active_cross_current_time, // active ccp 4
    output pgct_time_t set4_freewheel_blank_time, // fw blank 4
    output pgct_time_t set3_freewheel_blank_time, // fw blank 3
    output pgct_time_t set4_freewheel_cross_current_time, // fw ccp 4
    output pgct_peak_t ch1_peak_drive_code, // ch1 peak, active
    output pgct_peak_t ch2_peak_drive_code, // ch2 peak, active
    output pgct_peak_t ch3_peak_drive_code, // ch3 peak, active
    output pgct_peak_t ch1_fw_peak_drive_code, // ch1 peak, freewheel
    output pgct_peak_t ch2_fw_peak_drive_code, // ch2 peak, freewheel
    output pgct_peak_t ch3_fw_peak_drive_code, // ch3 peak, freewheel
    input wire logic [2:0] pre_phase, // per channel pre phases
    input wire logic [2:0] post_phase, // per channel post-charge
    input wire logic [2:0] fw_switching, // per channel fw mosfet
    output logic [5:0] drive_limit_code, // {ch3,ch2,ch1} applied peak
    output logic [2:0] drive_limit_en // per channel limit in force
);

    ////////////////////////////////////////////////////////////////////
    // state and decode

    pgct_top_st_t st_q, st_d;

    pgct_body_t disch_q, predis_q, act_q, fw_q;
    logic sense_q;

    logic hit_disch, hit_drive, hit_bank;
    logic we_disch, we_predis, we_act, we_fw, we_sense;

    // offsets compared once; banked offsets split on the bank bit
    assign hit_disch = (addr == `PGCT_OFS_DISCH);
    assign hit_drive = (addr == `PGCT_OFS_DRIVE);
    assign hit_bank = (addr == `PGCT_OFS_BANK);

    // banked write enables: only the selected register takes data
    assign we_disch = wr && hit_disch && !st_q.bank;
    assign we_predis = wr && hit_disch && st_q.bank;
    assign we_act = wr && hit_drive && !st_q.bank;
    assign we_fw = wr && hit_drive && st_q.bank;
    // option bit is shared, so either bank view may write it
    assign we_sense = wr && hit_disch;

    ////////////////////////////////////////////////////////////////////
    // register bodies

    // discharge codes, three channels of five bits
    pgct_field #(
        .W(`PGCT_BODY_W),
        .RST(`PGCT_RST_DISCH)
    ) u_disch (
        .clk(clk),
        .reset(reset),
        .we(we_disch),
        .wd(wdata[`PGCT_BODY_W-1:0]),
        .q(disch_q)
    );

    // initial predischarge codes
    pgct_field #(
        .W(`PGCT_BODY_W),
        .RST(`PGCT_RST_PREDIS)
    ) u_predis (
        .clk(clk),
        .reset(reset),
        .we(we_predis),
        .wd(wdata[`PGCT_BODY_W-1:0]),
        .q(predis_q)
    );

    // active timings and peak codes
    pgct_field #(
        .W(`PGCT_BODY_W),
        .RST(`PGCT_RST_DRIVE)
    ) u_act (
        .clk(clk),
        .reset(reset),
        .we(we_act),
        .wd(wdata[`PGCT_BODY_W-1:0]),
        .q(act_q)
    );

    // freewheel timings, same layout as the active body
    pgct_field #(
        .W(`PGCT_BODY_W),
        .RST(`PGCT_RST_DRIVE)
    ) u_fw (
        .clk(clk),
        .reset(reset),
        .we(we_fw),
        .wd(wdata[`PGCT_BODY_W-1:0]),
        .q(fw_q)
    );

    // sense amplifier output capacitor option
    pgct_field #(
        .W(1),
        .RST(`PGCT_RST_SENSE)
    ) u_sense (
        .clk(clk),
        .reset(reset),
        .we(we_sense),
        .wd(wdata[`PGCT_SENSE_BIT]),
        .q(sense_q)
    );

    ////////////////////////////////////////////////////////////////////
    // bank select and read path

    // reads see only the bank chosen beforehand; data lives one cycle
    always_comb begin
        st_d = st_q;
        st_d.rdata = '0;
        if (wr && hit_bank) begin
            st_d.bank = wdata[`PGCT_BANK_BIT];
        end
        if (rd) begin
            unique case (1'b1)
                hit_disch: begin
                    st_d.rdata = {sense_q,
                        st_q.bank ? predis_q : disch_q};
                end
                hit_drive: begin
                    // bit 15 stays zero in both views
                    st_d.rdata = {1'b0,
                        st_q.bank ? fw_q : act_q};
                end
                hit_bank: begin
                    st_d.rdata[`PGCT_BANK_BIT] = st_q.bank;
                end
                default: begin
                    // unmapped offsets read as zero
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q.bank <= `PGCT_RST_BANK;
            st_q.rdata <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign bank_sel = st_q.bank;

    ////////////////////////////////////////////////////////////////////
    // field outputs

    assign sense_cap_400p = sense_q;
    assign ch3_active_discharge_code = disch_q[`PGCT_CH3_CODE_LSB +: 5];
    assign ch2_active_discharge_code = disch_q[`PGCT_CH2_CODE_LSB +: 5];
    assign ch1_active_discharge_code = disch_q[`PGCT_CH1_CODE_LSB +: 5];
    assign ch3_initial_predischarge_code =
        predis_q[`PGCT_CH3_CODE_LSB +: 5];
    assign ch2_initial_predischarge_code =
        predis_q[`PGCT_CH2_CODE_LSB +: 5];
    assign ch1_initial_predischarge_code =
        predis_q[`PGCT_CH1_CODE_LSB +: 5];
    assign set4_active_blank_time = act_q[`PGCT_BLANK4_LSB +: 3];
    assign set4_active_cross_current_time = act_q[`PGCT_CROSS4_LSB +: 3];
    assign set3_active_blank_time = act_q[`PGCT_BLANK3_LSB +: 3];
    assign set4_freewheel_blank_time = fw_q[`PGCT_BLANK4_LSB +: 3];
    assign set4_freewheel_cross_current_time =
        fw_q[`PGCT_CROSS4_LSB +: 3];
    assign set3_freewheel_blank_time = fw_q[`PGCT_BLANK3_LSB +: 3];
    assign ch3_peak_drive_code = act_q[`PGCT_PEAK3_LSB +: 2];
    assign ch2_peak_drive_code = act_q[`PGCT_PEAK2_LSB +: 2];
    assign ch1_peak_drive_code = act_q[`PGCT_PEAK1_LSB +: 2];
    assign ch3_fw_peak_drive_code = fw_q[`PGCT_PEAK3_LSB +: 2];
    assign ch2_fw_peak_drive_code = fw_q[`PGCT_PEAK2_LSB +: 2];
    assign ch1_fw_peak_drive_code = fw_q[`PGCT_PEAK1_LSB +: 2];

    ////////////////////////////////////////////////////////////////////
    // per-channel drive limit

    // one selector per channel; limit lags the phase flags by a cycle
    for (genvar c = 0; c < 3; c++) begin : g_drv
        pgct_drive_sel u_sel (
            .clk(clk),
            .reset(reset),
            .act_peak(act_q[2*c +: 2]),
            .fw_peak(fw_q[2*c +: 2]),
            .fw_sel(fw_switching[c]),
            .pre_phase(pre_phase[c]),
            .post_phase(post_phase[c]),
            .limit(drive_limit_code[2*c +: 2]),
            .limit_en(drive_limit_en[c])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_bank0_wr(logic [`PGCT_ADDR_W-1:0] a);
        wr && addr == a && !st_q.bank;
    endsequence

    sequence s_bank1_wr(logic [`PGCT_ADDR_W-1:0] a);
        wr && addr == a && st_q.bank;
    endsequence

    property p_disch_write;
        s_bank0_wr(`PGCT_OFS_DISCH) |=>
            disch_q == $past(wdata[14:0]) && $stable(predis_q);
    endproperty
    a_disch_write: assert property (p_disch_write)
        else $error("discharge write went astray");

    property p_predis_write;
        s_bank1_wr(`PGCT_OFS_DISCH) |=>
            predis_q == $past(wdata[14:0]) && $stable(disch_q);
    endproperty
    a_predis_write: assert property (p_predis_write)
        else $error("predischarge write went astray");

    property p_fw_write;
        s_bank1_wr(`PGCT_OFS_DRIVE) |=>
            fw_q == $past(wdata[14:0]) && $stable(act_q);
    endproperty
    a_fw_write: assert property (p_fw_write)
        else $error("freewheel write went astray");

    property p_act_readback;
        s_bank0_wr(`PGCT_OFS_DRIVE) ##1
            (rd && addr == `PGCT_OFS_DRIVE && !st_q.bank) |=>
            rdata == {1'b0, $past(wdata[14:0], 2)};
    endproperty
    a_act_readback: assert property (p_act_readback)
        else $error("active drive readback mismatch");

    property p_res15;
        rd && hit_drive |=> rdata[15] == 1'b0;
    endproperty
    a_res15: assert property (p_res15)
        else $error("reserved bit 15 read as one");

    property p_sense;
        wr && hit_disch |=> sense_cap_400p == $past(wdata[15]) ##1
            (!$past(we_sense) || $stable(sense_cap_400p));
    endproperty
    a_sense: assert property (p_sense)
        else $error("sense option bit not taken");

    property p_reset_vals;
        $past(reset) |-> disch_q == `PGCT_RST_DISCH &&
            predis_q == `PGCT_RST_PREDIS && act_q == `PGCT_RST_DRIVE &&
            fw_q == `PGCT_RST_DRIVE && !sense_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("register reset value wrong");

    property p_fw_blank4;
        s_bank1_wr(`PGCT_OFS_DRIVE) |=>
            set4_freewheel_blank_time == $past(wdata[14:12]) &&
            $stable(set4_active_cross_current_time);
    endproperty
    a_fw_blank4: assert property (p_fw_blank4)
        else $error("freewheel blank 4 field wrong");

    property p_post_limit;
        post_phase[0] && !fw_switching[0] |=>
            drive_limit_en[0] && drive_limit_code[1:0] == $past(act_q[1:0]);
    endproperty
    a_post_limit: assert property (p_post_limit)
        else $error("post-charge limit not applied");

    property p_idle_limit;
        !pre_phase[2] && !post_phase[2] |=>
            !drive_limit_en[2] && drive_limit_code[5:4] == 2'h0;
    endproperty
    a_idle_limit: assert property (p_idle_limit)
        else $error("limit active outside phases");

    property p_read_once;
        !rd |=> rdata == '0;
    endproperty
    a_read_once: assert property (p_read_once)
        else $error("read data outlived its cycle");

endmodule

// file: design/placeholder_none.sv
`timescale 1ns/1ns

// file: tb/test_pwm_gate_current_timing_regs.sv
// self-checking bench for the banked pwm gate current and timing registers
// assumes: defines header and package compiled ahead, pgct_bank as the dut
`timescale 1ns/1ns
`include "pgct_defines.svh"

module test_pwm_gate_current_timing_regs
    import pgct_pkg::*;
();

logic clk;
logic reset;
logic wr;
logic rd;
logic [`PGCT_ADDR_W-1:0] addr;
logic [`PGCT_DATA_W-1:0] wdata;
logic [`PGCT_DATA_W-1:0] rdata;
logic [2:0] pre_ph;
logic [2:0] post_ph;
logic [2:0] fw_sw;
logic bank_sel;
logic sense;
pgct_code_t d1, d2, d3, p1, p2, p3;
pgct_time_t ab4, ab3, ac4, fb4, fb3, fc4;
pgct_peak_t ak1, ak2, ak3, fk1, fk2, fk3;
logic [5:0] lim_code;
logic [2:0] lim_en;
logic [15:0] disch_o;
logic [15:0] predis_o;
logic [15:0] act_o;
logic [15:0] fw_o;
int error_cnt;
int checked;

////////////////////////////////////////////////////////////////////////
// clock and register views rebuilt from the field outputs
always #2 clk = ~clk;

assign disch_o = {sense, d3, d2, d1};
assign predis_o = {sense, p3, p2, p1};
assign act_o = {1'b0, ab4, ac4, ab3, ak3, ak2, ak1};
assign fw_o = {1'b0, fb4, fc4, fb3, fk3, fk2, fk1};

pgct_bank i_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .bank_sel(bank_sel),
    .sense_cap_400p(sense),
    .ch1_active_discharge_code(d1),
    .ch2_active_discharge_code(d2),
    .ch3_active_discharge_code(d3),
    .ch1_initial_predischarge_code(p1),
    .ch2_initial_predischarge_code(p2),
    .ch3_initial_predischarge_code(p3),
    .set4_active_blank_time(ab4),
    .set3_active_blank_time(ab3),
    .set4_active_cross_current_time(ac4),
    .set4_freewheel_blank_time(fb4),
    .set3_freewheel_blank_time(fb3),
    .set4_freewheel_cross_current_time(fc4),
    .ch1_peak_drive_code(ak1), .ch2_peak_drive_code(ak2),
    .ch3_peak_drive_code(ak3), .ch1_fw_peak_drive_code(fk1),
    .ch2_fw_peak_drive_code(fk2), .ch3_fw_peak_drive_code(fk3),
    .pre_phase(pre_ph), .post_phase(post_ph), .fw_switching(fw_sw),
    .drive_limit_code(lim_code), .drive_limit_en(lim_en)
);

////////////////////////////////////////////////////////////////////////
// comparison and register port tasks, entered just after a rising edge
task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
    end
endtask

// one idle cycle after the strobe so wr is never driven twice per step
task wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
endtask

// read data stand only in the cycle after the strobe, sampled 1 ns after the edge
task rd_reg(input logic [4:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
endtask

// write strobe followed at once by a read strobe of the same offset
task wr_rd(input logic [4:0] a, input logic [15:0] d,
    input logic [15:0] exp);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
endtask

task set_bank(input logic b);
    wr_reg(`PGCT_OFS_BANK, {15'h0000, b});
endtask

// phase flags are taken on the first edge, which shows the answer; the check is made at the second
task lim_chk(input logic [2:0] pr, input logic [2:0] po,
    input logic [2:0] fw, input logic [5:0] code, input logic [2:0] en);
    pre_ph <= pr;
    post_ph <= po;
    fw_sw <= fw;
    @(posedge clk);
    @(posedge clk);
    check({10'h000, lim_code}, {10'h000, code});
    check({13'h0000, lim_en}, {13'h0000, en});
endtask

task chk_reset();
    check(disch_o, 16'h1CE7);
    check(predis_o, 16'h318C);
    check(act_o, 16'h4900);
    check(fw_o, 16'h4900);
    check({15'h0000, bank_sel}, 16'h0000);
    check({10'h000, lim_code}, 16'h0000);
    rd_reg(`PGCT_OFS_DISCH, 16'h1CE7);
    rd_reg(`PGCT_OFS_DRIVE, 16'h4900);
    set_bank(1'b1);
    check({15'h0000, bank_sel}, 16'h0001);
    rd_reg(`PGCT_OFS_DISCH, 16'h318C);
    rd_reg(`PGCT_OFS_DRIVE, 16'h4900);
    set_bank(1'b0);
endtask

task results();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////
// watchdog, generous against the under a hundred cycles the tests need
initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired before the tests ended");
    results();
end

////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    clk = 1'b0;
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    pre_ph = 3'h0;
    post_ph = 3'h0;
    fw_sw = 3'h0;
    error_cnt = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_reset();
    $display("test reset values done");
    // discharge view, sense bit shared with the predischarge view
    wr_reg(`PGCT_OFS_DISCH, 16'h8421);
    check(disch_o, 16'h8421);
    rd_reg(`PGCT_OFS_DISCH, 16'h8421);
    set_bank(1'b1);
    rd_reg(`PGCT_OFS_DISCH, 16'hB18C);
    wr_reg(`PGCT_OFS_DISCH, 16'h1234);
    check(predis_o, 16'h1234);
    rd_reg(`PGCT_OFS_DISCH, 16'h1234);
    set_bank(1'b0);
    rd_reg(`PGCT_OFS_DISCH, 16'h0421);
    $display("test discharge bank done");
    // drive views, reserved top bit dropped on write
    wr_reg(`PGCT_OFS_DRIVE, 16'hFFFF);
    check(act_o, 16'h7FFF);
    check(fw_o, 16'h4900);
    rd_reg(`PGCT_OFS_DRIVE, 16'h7FFF);
    set_bank(1'b1);
    rd_reg(`PGCT_OFS_DRIVE, 16'h4900);
    wr_reg(`PGCT_OFS_DRIVE, 16'hA5A5);
    check(fw_o, 16'h25A5);
    check(act_o, 16'h7FFF);
    rd_reg(`PGCT_OFS_DRIVE, 16'h25A5);
    $display("test drive bank done");
    // unmapped offset ignored on write and reads zero
    wr_reg(5'h0E, 16'hFFFF);
    rd_reg(5'h0E, 16'h0000);
    check(predis_o, 16'h1234);
    $display("test unmapped offset done");
    // peak codes: active {11,10,01}, freewheel {00,01,10}
    wr_rd(`PGCT_OFS_DRIVE, 16'h4906, 16'h4906);
    set_bank(1'b0);
    wr_rd(`PGCT_OFS_DRIVE, 16'hC939, 16'h4939);
    lim_chk(3'b000, 3'b111, 3'b000, 6'h39, 3'b111);
    lim_chk(3'b111, 3'b000, 3'b111, 6'h06, 3'b111);
    lim_chk(3'b001, 3'b100, 3'b010, 6'h31, 3'b101);
    lim_chk(3'b010, 3'b000, 3'b010, 6'h04, 3'b010);
    lim_chk(3'b000, 3'b000, 3'b111, 6'h00, 3'b000);
    $display("test drive limit done");
    // second reset in mid-run restores every register
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_reset();
    $display("test second reset done");
    results();
end

endmodule
